// ===== inc/servo_cfg.svh
// servo_cfg.svh: constants of the servo pulse generator
// assumes a 200 MHz system clock; all times in their own unit
`ifndef SERVO_CFG_SVH
`define SERVO_CFG_SVH

`define CLK_MHZ      200
`define TICK_US      1
`define TICK_CYC     (`TICK_US * `CLK_MHZ)
// repetition frequencies and their periods in us
`define FREQ0_HZ     50
`define FREQ1_HZ     125
`define FREQ2_HZ     250
`define FREQ3_HZ     333
`define PER0_US      (1000000 / `FREQ0_HZ)
`define PER1_US      (1000000 / `FREQ1_HZ)
`define PER2_US      (1000000 / `FREQ2_HZ)
`define PER3_US      (1000000 / `FREQ3_HZ)
// pulse widths in us
`define W_MIN_US     500
`define W_MAX_US     2500
`define W_RST_US     1500
`define W_STEP_US    10
`define SW_MIN_US    1000
`define SW_MAX_US    2000
// sweep setting: us between 1 us width steps; period = 2 ms * setting
`define SWP_MIN      250
`define SWP_MAX      5000
`define SWP_RST      1000
`define SWP_STEP     50
// button timing in ms
`define DEB_MS       20
`define LONG_MS      600
`define DBL_MS       400
`define MS_CYC(ms)   ((ms) * 1000 * `CLK_MHZ)
// register map
`define REG_CTRL     8'h00
`define REG_WIDTH    8'h04
`define REG_SWEEP    8'h08
`define REG_STAT     8'h0C
`define CTRL_RUN     0
`define CTRL_TGT     1
`define CTRL_SWP     2
`define CTRL_FRQ     4
`define RESP_OK      2'h0
`define RESP_ERR     2'h2

`endif

// ===== inc/servo_pkg.sv
// servo_pkg: types shared by the servo pulse generator files
// assumes nothing beyond a SystemVerilog compiler
package servo_pkg;
   typedef enum logic [2:0] {
      M_IDLE  = 3'b001,
      M_WIDTH = 3'b010,
      M_FREQ  = 3'b100
   } mode_e;

   typedef struct packed {
      logic shrt;
      logic lng;
      logic dbl;
      logic cw;
      logic ccw;
   } ui_evt_s;

   typedef logic [14:0] us_t;
   typedef logic [1:0]  freq_t;
endpackage

// ===== hdl/ui_input.sv
// ui_input: button and rotary encoder conditioning
// assumes raw pins from outside the clock domain; events are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
`include "servo_cfg.svh"

module ui_input
   import servo_pkg::*;
#(
   parameter int DEB_CYC  = `MS_CYC(`DEB_MS),
   parameter int LONG_CYC = `MS_CYC(`LONG_MS),
   parameter int DBL_CYC  = `MS_CYC(`DBL_MS)
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic btn_n,
   input  wire logic enc_a,
   input  wire logic enc_b,
   output ui_evt_s   evt
);
   localparam int CW = $clog2(LONG_CYC + DBL_CYC + DEB_CYC) + 1;

   if (DEB_CYC < 2 || LONG_CYC < 2 || DBL_CYC < 2) begin : g_chk
      $error("ui_input: timing counts must be at least 2");
   end

   logic          btn_s1, btn_s2, a_s1, a_s2, a_s3, b_s1, b_s2;
   logic          pressed, long_done, pend;
   logic [CW-1:0] deb_cnt, hold_cnt, gap_cnt;

   // ----------------------------------------------------------------
   // synchronisers and debounce
   // ----------------------------------------------------------------
   wire deb_diff = (~btn_s2) != pressed;
   wire deb_done = deb_diff && (deb_cnt == CW'(DEB_CYC - 1));
   wire release_ev = deb_done && pressed;
   wire short_ev   = release_ev && !long_done;
   wire long_ev    = pressed && !long_done && (hold_cnt == CW'(LONG_CYC - 1));
   wire gap_out    = pend && (gap_cnt == CW'(DBL_CYC - 1));
   wire a_rise     = a_s2 && !a_s3;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // the button idles high; a low reset value would look like a press
         {btn_s1, btn_s2} <= 2'h3;
         {a_s1, a_s2, a_s3, b_s1, b_s2} <= '0;
      end else begin
         {btn_s2, btn_s1} <= {btn_s1, btn_n};
         {a_s3, a_s2, a_s1} <= {a_s2, a_s1, enc_a};
         {b_s2, b_s1} <= {b_s1, enc_b};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pressed <= 1'b0;
         deb_cnt <= '0;
      end else begin
         deb_cnt <= (deb_diff && !deb_done) ? deb_cnt + 1'b1 : '0;
         if (deb_done) begin
            pressed <= ~btn_s2;
         end
      end
   end

   // ----------------------------------------------------------------
   // press classification
   // ----------------------------------------------------------------
   // a short press is held back one gap so a second one can make it a double
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_cnt  <= '0;
         long_done <= 1'b0;
         pend      <= 1'b0;
         gap_cnt   <= '0;
      end else begin
         hold_cnt  <= (pressed && !long_done) ? hold_cnt + 1'b1 : '0;
         if (long_ev) begin
            long_done <= 1'b1;
         end else if (!pressed) begin
            long_done <= 1'b0;
         end
         gap_cnt <= (pend && !short_ev) ? gap_cnt + 1'b1 : '0;
         if (short_ev) begin
            pend <= !pend;
         end else if (gap_out) begin
            pend <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         evt <= '0;
      end else begin
         evt.shrt <= gap_out && !short_ev;
         evt.dbl  <= short_ev && pend;
         evt.lng  <= long_ev;
         evt.cw   <= a_rise && !b_s2;
         evt.ccw  <= a_rise && b_s2;
      end
   end
endmodule
`default_nettype wire

// ===== hdl/servo_pulse_generator.sv
// servo_pulse_generator: servo pulse train with button/encoder and AXI4-Lite control
// assumes one 200 MHz clock; button and encoder are raw pins
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "servo_cfg.svh"

module servo_pulse_generator
   import servo_pkg::*;
#(
   parameter int ADDR_W   = 8,
   parameter int DEB_CYC  = `MS_CYC(`DEB_MS),
   parameter int LONG_CYC = `MS_CYC(`LONG_MS),
   parameter int DBL_CYC  = `MS_CYC(`DBL_MS)
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              btn_n,
   input  wire logic              enc_a,
   input  wire logic              enc_b,
   output logic [2:0]             probe_out,
   output logic [2:0]             probe_oe,
   output logic                   res_sel,
   output logic                   tgt_ind,
   output logic                   sweep_ind,
   output logic                   active
);
   if (ADDR_W < 8) begin : g_chk
      $error("servo_pulse_generator: ADDR_W must be at least 8");
   end

   mode_e             mode;
   ui_evt_s           evt;
   us_t               width_set, swp_set, sw_w, sw_cnt, cnt, per_q, wid_q;
   freq_t             freq_idx;
   logic              sweep_en, sw_up, pwm;
   logic [7:0]        div;
   logic              aw_hold, w_hold;
   logic [ADDR_W-1:0] wa;
   logic [31:0]       wd;
   logic [3:0]        ws;

   default clocking main_clk @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ui_input #(.DEB_CYC (DEB_CYC), .LONG_CYC (LONG_CYC), .DBL_CYC (DBL_CYC)) u_ui (
      .aclk (aclk), .aresetn (aresetn), .btn_n (btn_n),
      .enc_a (enc_a), .enc_b (enc_b), .evt (evt)
   );
   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   function automatic logic [31:0] rd_val(input logic [ADDR_W-1:0] a);
      logic [31:0] v;
      v = 32'h0;
      if (a == ADDR_W'(`REG_CTRL)) begin
         v[`CTRL_RUN]            = active;
         v[`CTRL_TGT]            = (mode == M_FREQ);
         v[`CTRL_SWP]            = sweep_en;
         v[`CTRL_FRQ+1:`CTRL_FRQ] = freq_idx;
      end else if (a == ADDR_W'(`REG_WIDTH)) begin
         v[14:0] = width_set;
      end else if (a == ADDR_W'(`REG_SWEEP)) begin
         v[14:0] = swp_set;
      end else if (a == ADDR_W'(`REG_STAT)) begin
         v = {15'h0, pwm, 1'b0, wid_q};
      end
      return v;
   endfunction
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return a == ADDR_W'(`REG_CTRL) || a == ADDR_W'(`REG_WIDTH) ||
             a == ADDR_W'(`REG_SWEEP) || a == ADDR_W'(`REG_STAT);
   endfunction
   wire [31:0] wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
   wire [31:0] wv    = (rd_val(wa) & ~wmask) | (wd & wmask);
   wire        wr_do = aw_hold && w_hold && !s_axi_bvalid;
   wire        wr_c  = wr_do && wa == ADDR_W'(`REG_CTRL);
   wire        wr_w  = wr_do && wa == ADDR_W'(`REG_WIDTH);
   wire        wr_s  = wr_do && wa == ADDR_W'(`REG_SWEEP);
   wire        wr_any = wr_c || wr_w || wr_s;
   wire us_t   wv_u  = wv[14:0];
   wire us_t   wv_w  = (wv_u < us_t'(`W_MIN_US)) ? us_t'(`W_MIN_US) :
                       (wv_u > us_t'(`W_MAX_US)) ? us_t'(`W_MAX_US) : wv_u;
   wire us_t   wv_s  = (wv_u < us_t'(`SWP_MIN)) ? us_t'(`SWP_MIN) :
                       (wv_u > us_t'(`SWP_MAX)) ? us_t'(`SWP_MAX) : wv_u;
   wire mode_e wv_m  = !wv[`CTRL_RUN] ? M_IDLE : wv[`CTRL_TGT] ? M_FREQ : M_WIDTH;

   assign s_axi_awready = !aw_hold;
   assign s_axi_wready  = !w_hold;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {aw_hold, w_hold, s_axi_bvalid, s_axi_rvalid} <= '0;
         {wa, wd, ws, s_axi_rdata} <= '0;
         s_axi_bresp <= `RESP_OK;
         s_axi_rresp <= `RESP_OK;
      end else begin
         if (s_axi_awvalid && !aw_hold) begin
            aw_hold <= 1'b1;
            wa      <= s_axi_awaddr;
         end else if (wr_do) begin
            aw_hold <= 1'b0;
         end
         if (s_axi_wvalid && !w_hold) begin
            w_hold <= 1'b1;
            {wd, ws} <= {s_axi_wdata, s_axi_wstrb};
         end else if (wr_do) begin
            w_hold <= 1'b0;
         end
         if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            // status is read-only, so a write to it is refused like a hole
            s_axi_bresp  <= wr_any ? `RESP_OK : `RESP_ERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val(s_axi_araddr);
            s_axi_rresp  <= mapped(s_axi_araddr) ? `RESP_OK : `RESP_ERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // user settings
   // ----------------------------------------------------------------
   wire us_t   w_up   = (width_set + us_t'(`W_STEP_US) > us_t'(`W_MAX_US)) ?
                        us_t'(`W_MAX_US) : width_set + us_t'(`W_STEP_US);
   wire us_t   w_dn   = (width_set < us_t'(`W_MIN_US + `W_STEP_US)) ?
                        us_t'(`W_MIN_US) : width_set - us_t'(`W_STEP_US);
   wire us_t   next_width = evt.cw ? w_up : evt.ccw ? w_dn : width_set;
   wire us_t   s_up   = (swp_set + us_t'(`SWP_STEP) > us_t'(`SWP_MAX)) ?
                        us_t'(`SWP_MAX) : swp_set + us_t'(`SWP_STEP);
   wire us_t   s_dn   = (swp_set < us_t'(`SWP_MIN + `SWP_STEP)) ?
                        us_t'(`SWP_MIN) : swp_set - us_t'(`SWP_STEP);
   wire us_t   next_swp = evt.cw ? s_up : evt.ccw ? s_dn : swp_set;
   wire freq_t next_idx = (evt.cw && freq_idx != 2'h3) ? freq_idx + 2'h1 :
                          (evt.ccw && freq_idx != 2'h0) ? freq_idx - 2'h1 : freq_idx;

   // a bus write in the same cycle as a user event takes precedence
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode      <= M_IDLE;
         width_set <= us_t'(`W_RST_US);
         swp_set   <= us_t'(`SWP_RST);
         freq_idx  <= 2'h0;
         sweep_en  <= 1'b0;
      end else if (wr_any) begin
         if (wr_c) begin
            mode     <= wv_m;
            sweep_en <= wv[`CTRL_SWP];
            freq_idx <= wv[`CTRL_FRQ+1:`CTRL_FRQ];
         end
         if (wr_w) width_set <= wv_w;
         if (wr_s) swp_set <= wv_s;
      end else begin
         unique case (mode)
            M_IDLE: begin
            end
            M_WIDTH: begin
               if (evt.dbl) mode <= M_IDLE;
               else if (evt.shrt) mode <= M_FREQ;
               else if (evt.lng) width_set <= us_t'(`W_RST_US);
               else if (sweep_en) swp_set <= next_swp;
               else width_set <= next_width;
            end
            M_FREQ: begin
               if (evt.dbl) mode <= M_IDLE;
               else if (evt.shrt) mode <= M_WIDTH;
               else if (evt.lng) sweep_en <= !sweep_en;
               else freq_idx <= next_idx;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // sweep engine and pulse timing
   // ----------------------------------------------------------------
   wire tick = (div == 8'(`TICK_CYC - 1));
   wire us_t per_live = (freq_idx == 2'h0) ? us_t'(`PER0_US) :
                        (freq_idx == 2'h1) ? us_t'(`PER1_US) :
                        (freq_idx == 2'h2) ? us_t'(`PER2_US) : us_t'(`PER3_US);
   wire us_t wid_live = sweep_en ? sw_w : width_set;
   wire      per_end  = tick && (cnt == per_q - us_t'(1));
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div <= 8'h00;
      end else begin
         div <= tick ? 8'h00 : div + 8'h01;
      end
   end

   // one 1 us step every swp_set us: 2000 steps make one up-down excursion
   always_ff @(posedge aclk) begin
      if (!aresetn || !sweep_en) begin
         sw_w   <= us_t'(`SW_MIN_US);
         sw_up  <= 1'b1;
         sw_cnt <= '0;
      end else if (tick) begin
         if (sw_cnt >= swp_set - us_t'(1)) begin
            sw_cnt <= '0;
            sw_w   <= sw_up ? sw_w + us_t'(1) : sw_w - us_t'(1);
            if (sw_up && sw_w == us_t'(`SW_MAX_US - 1)) sw_up <= 1'b0;
            if (!sw_up && sw_w == us_t'(`SW_MIN_US + 1)) sw_up <= 1'b1;
         end else begin
            sw_cnt <= sw_cnt + us_t'(1);
         end
      end
   end

   // settings are sampled only at a period boundary, never mid-pulse
   always_ff @(posedge aclk) begin
      if (!aresetn || mode == M_IDLE) begin
         cnt   <= '0;
         per_q <= us_t'(`PER0_US);
         wid_q <= us_t'(`W_RST_US);
         pwm   <= 1'b0;
      end else begin
         if (per_end) begin
            cnt   <= '0;
            per_q <= per_live;
            wid_q <= wid_live;
         end else if (tick) begin
            cnt <= cnt + us_t'(1);
         end
         pwm <= (cnt < wid_q);
      end
   end

   assign active    = (mode != M_IDLE);
   assign probe_out = {1'b0, pwm && active, 1'b0};
   assign probe_oe  = active ? 3'b111 : 3'b000;
   assign res_sel   = active;
   assign tgt_ind   = (mode == M_FREQ);
   assign sweep_ind = sweep_en;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_rate;
      active |-> per_q inside {us_t'(`PER0_US), us_t'(`PER1_US), us_t'(`PER2_US), us_t'(`PER3_US)};
   endproperty
   a_rate: assert property (p_rate) else $error("period not an allowed rate");
   property p_wrange;
      wid_q >= us_t'(`W_MIN_US) && wid_q <= us_t'(`W_MAX_US);
   endproperty
   a_wrange: assert property (p_wrange) else $error("pulse width out of range");
   property p_sweep;
      sweep_en |-> sw_w >= us_t'(`SW_MIN_US) && sw_w <= us_t'(`SW_MAX_US);
   endproperty
   a_sweep: assert property (p_sweep) else $error("sweep width out of range");
   property p_cw;
      mode == M_WIDTH && !sweep_en && !wr_any && evt == 5'b00010
      |=> width_set == (($past(width_set) + us_t'(`W_STEP_US) > us_t'(`W_MAX_US)) ?
                        us_t'(`W_MAX_US) : $past(width_set) + us_t'(`W_STEP_US));
   endproperty
   a_cw: assert property (p_cw) else $error("clockwise step did not lengthen");
   property p_long;
      mode == M_WIDTH && evt.lng && !evt.dbl && !evt.shrt && !wr_any
      |=> width_set == us_t'(`W_RST_US);
   endproperty
   a_long: assert property (p_long) else $error("long press did not restore width");
   property p_short;
      mode == M_WIDTH && evt.shrt && !evt.dbl && !wr_any |=> tgt_ind ##1 tgt_ind;
   endproperty
   a_short: assert property (p_short) else $error("short press did not switch target");
   property p_fstep;
      mode == M_FREQ && evt == 5'b00010 && freq_idx != 2'h3 && !wr_any
      |=> freq_idx == $past(freq_idx) + 2'h1;
   endproperty
   a_fstep: assert property (p_fstep) else $error("frequency did not step");
   property p_stog;
      mode == M_FREQ && evt.lng && !evt.dbl && !evt.shrt && !wr_any
      |=> sweep_ind != $past(sweep_ind);
   endproperty
   a_stog: assert property (p_stog) else $error("long press did not toggle sweep");
   property p_swp;
      mode == M_WIDTH && sweep_en && evt == 5'b00001 && !wr_any
      |=> $stable(width_set) && swp_set <= $past(swp_set);
   endproperty
   a_swp: assert property (p_swp) else $error("encoder did not act on sweep period");
   property p_exit;
      active && evt.dbl && !wr_any |=> probe_oe == 3'b000 ##1 !probe_out[1];
   endproperty
   a_exit: assert property (p_exit) else $error("double press did not release output");
   property p_pins;
      active |-> probe_oe == 3'b111 && !probe_out[0] && !probe_out[2] && res_sel;
   endproperty
   a_pins: assert property (p_pins) else $error("outer probes not grounded");
   property p_hold;
      active && !per_end |=> $stable(wid_q) && $stable(per_q);
   endproperty
   a_hold: assert property (p_hold) else $error("setting applied mid-period");
   property p_lin;
      sweep_en && $past(sweep_en) && $changed(sw_w)
      |-> sw_w == $past(sw_w) + us_t'(1) || sw_w == $past(sw_w) - us_t'(1);
   endproperty
   a_lin: assert property (p_lin) else $error("sweep moved by more than one step");
endmodule
`default_nettype wire

// ===== sim/servo_model.sv
// servo_model: hobby servo hung on the three probe pins
// assumes probe pins driven only while their enables are high
`timescale 1ns/1ps
`default_nettype none

module servo_model (
   input  wire logic [2:0] probe_out,
   input  wire logic [2:0] probe_oe,
   input  wire logic       aclk,
   output logic            fault,
   output int              rises
);
   logic last;

   // the servo only listens; outer probes must sit at ground when driven
   initial begin
      fault = 1'b0;
      rises = 0;
      last = 1'b0;
      forever begin
         @(posedge aclk);
         if ((probe_oe[0] && probe_out[0]) || (probe_oe[2] && probe_out[2])) begin
            fault = 1'b1;
         end
         if (probe_oe[1] && probe_out[1] && !last) begin
            rises++;
         end
         last = probe_oe[1] & probe_out[1];
      end
   end
endmodule

`default_nettype wire

// ===== sim/servo_pulse_generator_bench.sv
// servo_pulse_generator_bench: register, button and encoder scenarios
// assumes shortened button timing; full pwm periods are too long to run
`timescale 1ns/1ps
`default_nettype none
`include "servo_cfg.svh"

module servo_pulse_generator_bench;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rd;
   logic [3:0]  wstrb = 0;
   logic btn_n = 1, enc_a = 0, enc_b = 0, fault;
   wire logic awready, wready, bvalid, arready, rvalid, res_sel, tgt_ind, sweep_ind, active;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [2:0]  probe_out, probe_oe;
   logic [1:0] resp;
   int bad_count = 0, samples_checked = 0, cyc = 0, rises;

   servo_pulse_generator #(.DEB_CYC(4), .LONG_CYC(40), .DBL_CYC(30)) DUT (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .btn_n(btn_n),
      .enc_a(enc_a), .enc_b(enc_b), .probe_out(probe_out), .probe_oe(probe_oe),
      .res_sel(res_sel), .tgt_ind(tgt_ind), .sweep_ind(sweep_ind), .active(active));
   servo_model servo (.probe_out(probe_out), .probe_oe(probe_oe), .aclk(aclk),
      .fault(fault), .rises(rises));

   always #2.5 aclk = ~aclk;

   // -----------------------------------------------------------
   // shared tasks
   // -----------------------------------------------------------
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // a hang here is cut by the cycle ceiling below
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_done, w_done;
      @(posedge aclk);
      awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1; wvalid <= 1; bready <= 1;
      aw_done = 0; w_done = 0;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (awvalid && awready) begin awvalid <= 0; aw_done = 1; end
         if (wvalid && wready) begin wvalid <= 0; w_done = 1; end
      end
      while (!bvalid) @(posedge aclk);
      resp = bresp;
      bready <= 0;
   endtask

   task automatic rdr(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do @(posedge aclk); while (!arready);
      arvalid <= 0;
      do @(posedge aclk); while (!rvalid);
      rd = rdata; resp = rresp;
      rready <= 0;
   endtask

   task automatic press(input int hold, input int gap);
      @(posedge aclk) btn_n <= 0;
      repeat (hold) @(posedge aclk);
      btn_n <= 1;
      repeat (gap) @(posedge aclk);
   endtask

   task automatic step(input logic ccw);
      @(posedge aclk) enc_b <= ccw;
      repeat (3) @(posedge aclk);
      enc_a <= 1;
      repeat (6) @(posedge aclk);
      enc_a <= 0;
      repeat (10) @(posedge aclk);
   endtask

   // -----------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------
   task automatic t_regs;
      chk(probe_oe, 0);
      rdr(`REG_WIDTH); chk(rd, `W_RST_US);
      wr(`REG_WIDTH, 100); rdr(`REG_WIDTH); chk(rd, `W_MIN_US);
      wr(`REG_WIDTH, 9999); rdr(`REG_WIDTH); chk(rd, `W_MAX_US);
      wr(`REG_SWEEP, 1); rdr(`REG_SWEEP); chk(rd, `SWP_MIN);
      wr(8'h10, 5); chk(resp, `RESP_ERR);
      rdr(8'h10); chk(resp, `RESP_ERR);
      wr(`REG_STAT, 5); chk(resp, `RESP_ERR);
   endtask

   task automatic t_start;
      for (int k = 0; k < 4; k++) begin
         wr(`REG_CTRL, (k << 4) | 1);
         rdr(`REG_CTRL); chk({rd[5:4], rd[0]}, (k << 1) | 1);
      end
      chk({res_sel, probe_oe}, 4'hF);
      chk({probe_out[2], probe_out[0]}, 0);
      wr(`REG_WIDTH, 2000);
      repeat (20) @(posedge aclk);
      // the opening period keeps its latched width despite the new value
      rdr(`REG_STAT); chk({rd[16], rd[14:0]}, {1'b1, 15'(`W_RST_US)});
      wr(`REG_CTRL, 1);
   endtask

   task automatic t_enc;
      wr(`REG_WIDTH, 510);
      step(0); rdr(`REG_WIDTH); chk(rd, 520);
      repeat (3) step(1);
      rdr(`REG_WIDTH); chk(rd, `W_MIN_US);
      press(80, 70); rdr(`REG_WIDTH); chk(rd, `W_RST_US);
   endtask

   task automatic t_button;
      press(12, 70); chk(tgt_ind, 1);
      step(0); rdr(`REG_CTRL); chk(rd[5:4], 1);
      step(1); step(1); rdr(`REG_CTRL); chk(rd[5:4], 0);
      press(80, 70); chk(sweep_ind, 1);
      press(12, 70); chk(tgt_ind, 0);
      step(0); rdr(`REG_SWEEP); chk(rd, `SWP_MIN + `SWP_STEP);
      step(1); rdr(`REG_SWEEP); chk(rd, `SWP_MIN);
      press(12, 12); press(12, 70); chk({active, probe_oe}, 0);
   endtask

   always @(posedge aclk) begin
      cyc++;
      if (cyc == 70000) begin
         bad_count++;
         end_of_test();
      end
   end

   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      t_regs();
      t_start();
      t_enc();
      t_button();
      // sweep stays on after exit; wait out one 250 us step so the sweep engine moves
      repeat (51000) @(posedge aclk);
      chk({fault, rises != 0}, 1);
      end_of_test();
   end
endmodule

`default_nettype wire
